// ---- hdl/scp_pkg.sv ----
// Purpose: constants and types of the serial control port slave
// Assumes: 13-bit register addresses, 8-bit register data
// Notes: shared by the port logic and its assertion checker
package scp_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int WORD_W = 21;
  localparam int FIFO_DEPTH = 16;

  // register addresses seen by the port
  localparam logic [12:0] CFG_ADDR = 13'h0000;
  localparam logic [12:0] RBSEL_ADDR = 13'h0001;
  localparam logic [12:0] UPDATE_ADDR = 13'h000F;
  localparam logic [12:0] SYNC_ADDR = 13'h0403;

  // field positions
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_ASC_LO = 2;
  localparam int CFG_ASC_HI = 5;
  localparam int CFG_4W_LO = 3;
  localparam int CFG_4W_HI = 4;
  localparam int RBSEL_BIT = 5;
  localparam int UPDATE_BIT = 0;
  localparam int SYNC_BIT = 0;
  localparam int INSTR_RW_BIT = 15;

  // reset values, two-wire address prefix and counts
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [4:0] I2C_ADDR_HI = 5'h15;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ = 2'b11
  } scp_phase_t;

  typedef struct packed {
    logic [1:0] sclkS;
    logic sclkPrev;
    logic [1:0] csS;
    logic [1:0] sdioS;
    logic [1:0] sp0S;
    logic [1:0] sp1S;
    logic [1:0] strapCnt;
    logic strapDone;
    logic spiActive;
    logic [6:0] i2cAddr;
    logic i2cValid;
    scp_phase_t phase;
    logic [3:0] bitCnt;
    logic [15:0] rxShift;
    logic [7:0] txShift;
    logic [12:0] addr;
    logic lsbCur;
    logic ascCur;
    logic fourWire;
    logic [7:0] cfg;
    logic readActive;
    logic rdReq;
    logic rdLoad;
    logic [12:0] rdAddr;
    logic pendValid;
    logic [20:0] pendWord;
    logic overflow;
    logic ioUpdate;
    logic syncReq;
    logic sdioOut;
    logic sdioOe;
    logic sdoOut;
    logic sdoOe;
  } scp_state_t;

endpackage

// ---- hdl/scp_fifo.sv ----
// Purpose: write queue between the serial port and the register map
// Assumes: single clock, synchronous active-high reset
// Notes: output word and valid come straight from registers
`timescale 1ns/10ps
module scp_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] count_r;
  logic outValid_r;
  logic [WIDTH-1:0] outData_r;
  logic push;
  logic load;

  assign inReady = (count_r != CW'(DEPTH));
  assign push = inValid && inReady;
  // refill the output stage whenever it is empty or being drained
  assign load = (count_r != '0) && (!outValid_r || outReady);
  assign outValid = outValid_r;
  assign outData = outData_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      outValid_r <= 1'b0;
      outData_r <= '0;
    end else begin
      if (push) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r <= PW'((32'(wrPtr_r) + 1) % DEPTH);
      end
      if (load) begin
        outData_r <= mem[rdPtr_r];
        rdPtr_r <= PW'((32'(rdPtr_r) + 1) % DEPTH);
        outValid_r <= 1'b1;
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
      count_r <= CW'(32'(count_r) + 32'(push) - 32'(load));
    end
  end

endmodule

// ---- hdl/scp_spi_slave.sv ----
// Purpose: serial control port slave, SPI side, with strap-based selection
// Assumes: sclk, csN, sdio and straps are asynchronous pins; sclk well
//   below the system clock so each edge is seen after synchronising
// Notes: writes leave through a queue to the register map, except cfg writes, kept here; reads fetch
//   one byte at a time from the map over rdReq/rdAddr/rdData, cfg reads from the local copy
`timescale 1ns/10ps

module scp_spi_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic serialDataOut,
  output logic serialDataOutOe,
  input wire logic portSelectPin0,
  input wire logic portSelectPin1,
  output logic spiActive,
  output logic [6:0] i2cAddr,
  output logic i2cAddrValid,
  output logic rdReq,
  output logic [12:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic readActive,
  output logic wrValid,
  input wire logic wrReady,
  output logic [12:0] wrAddr,
  output logic [7:0] wrData,
  output logic wrOverflow,
  output logic ioUpdate,
  output logic syncPulseRequest
);

  scp_pkg::scp_state_t r_r;
  scp_pkg::scp_state_t r_nxt;

  logic rise;
  logic fall;
  logic csHigh;
  logic inBit;
  logic [15:0] rxNext;
  logic [7:0] byteIn;
  logic [12:0] stepAddr;
  logic fifoInReady;
  logic pushNow;
  logic [20:0] fifoOut;
  logic popNow;

  assign rise = r_r.sclkS[1] && !r_r.sclkPrev;
  assign fall = !r_r.sclkS[1] && r_r.sclkPrev;
  assign csHigh = r_r.csS[1];
  assign inBit = r_r.sdioS[1];
  // lsb-first fills from the top so fields land where msb-first puts them
  assign rxNext = r_r.lsbCur ? {inBit, r_r.rxShift[15:1]} :
    {r_r.rxShift[14:0], inBit};
  assign byteIn = r_r.lsbCur ? rxNext[15:8] : rxNext[7:0];
  assign stepAddr = r_r.ascCur ? r_r.addr + 13'h0001 :
    r_r.addr - 13'h0001;
  assign pushNow = r_r.pendValid && fifoInReady;
  assign popNow = wrValid && wrReady;

  scp_fifo #(
    .WIDTH(scp_pkg::WORD_W),
    .DEPTH(scp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(r_r.pendValid),
    .inReady(fifoInReady),
    .inData(r_r.pendWord),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(fifoOut)
  );

  assign wrAddr = fifoOut[20:8];
  assign wrData = fifoOut[7:0];

  always_comb begin
    r_nxt = r_r;
    r_nxt.sclkS = {r_r.sclkS[0], sclk};
    r_nxt.sclkPrev = r_r.sclkS[1];
    r_nxt.csS = {r_r.csS[0], csN};
    r_nxt.sdioS = {r_r.sdioS[0], sdioIn};
    r_nxt.sp0S = {r_r.sp0S[0], portSelectPin0};
    r_nxt.sp1S = {r_r.sp1S[0], portSelectPin1};
    r_nxt.rdReq = 1'b0;
    r_nxt.rdLoad = r_r.rdReq;
    r_nxt.ioUpdate = 1'b0;
    r_nxt.syncReq = 1'b0;

    // straps caught once after reset, then frozen
    if (!r_r.strapDone) begin
      if (r_r.strapCnt == scp_pkg::STRAP_SETTLE) begin
        r_nxt.strapDone = 1'b1;
        r_nxt.spiActive = !r_r.sp1S[1] && !r_r.sp0S[1];
        // pin 0 alone gives low bits 00, both pins high give 01
        r_nxt.i2cAddr = {scp_pkg::I2C_ADDR_HI, 1'b0,
          r_r.sp1S[1]};
        r_nxt.i2cValid = r_r.sp0S[1];
      end else begin
        r_nxt.strapCnt = r_r.strapCnt + 2'h1;
      end
    end

    // commit and sync request leave in order behind earlier writes
    if (popNow && fifoOut[20:8] == scp_pkg::UPDATE_ADDR) begin
      r_nxt.ioUpdate = fifoOut[scp_pkg::UPDATE_BIT];
    end
    if (popNow && fifoOut[20:8] == scp_pkg::SYNC_ADDR) begin
      r_nxt.syncReq = fifoOut[scp_pkg::SYNC_BIT];
    end

    if (pushNow) begin
      r_nxt.pendValid = 1'b0;
    end

    if (csHigh || !r_r.spiActive) begin
      r_nxt.phase = scp_pkg::PH_IDLE;
      r_nxt.bitCnt = 4'h0;
      r_nxt.sdioOe = 1'b0;
      r_nxt.sdoOe = 1'b0;
    end else if (r_r.phase == scp_pkg::PH_IDLE) begin
      // mode bits written last transfer take effect here
      r_nxt.phase = scp_pkg::PH_INSTR;
      r_nxt.bitCnt = 4'h0;
      r_nxt.lsbCur = r_r.cfg[scp_pkg::CFG_LSB_LO] ||
        r_r.cfg[scp_pkg::CFG_LSB_HI];
      r_nxt.ascCur = r_r.cfg[scp_pkg::CFG_ASC_LO] ||
        r_r.cfg[scp_pkg::CFG_ASC_HI];
      r_nxt.fourWire = r_r.cfg[scp_pkg::CFG_4W_LO] ||
        r_r.cfg[scp_pkg::CFG_4W_HI];
    end else if (rise) begin
      r_nxt.rxShift = rxNext;
      r_nxt.bitCnt = r_r.bitCnt + 4'h1;
      case (r_r.phase)
        scp_pkg::PH_INSTR: begin
          if (r_r.bitCnt == scp_pkg::INSTR_LAST) begin
            r_nxt.bitCnt = 4'h0;
            r_nxt.addr = rxNext[12:0];
            if (rxNext[scp_pkg::INSTR_RW_BIT]) begin
              r_nxt.phase = scp_pkg::PH_READ;
              r_nxt.rdReq = 1'b1;
              r_nxt.rdAddr = rxNext[12:0];
            end else begin
              r_nxt.phase = scp_pkg::PH_WRITE;
            end
          end
        end
        scp_pkg::PH_WRITE: begin
          if (r_r.bitCnt == scp_pkg::BYTE_LAST) begin
            r_nxt.bitCnt = 4'h0;
            r_nxt.addr = stepAddr;
            if (r_r.addr == scp_pkg::CFG_ADDR) begin
              r_nxt.cfg = byteIn;
            end else begin
              if (r_r.pendValid && !pushNow) begin
                r_nxt.overflow = 1'b1;
              end
              r_nxt.pendValid = 1'b1;
              r_nxt.pendWord = {r_r.addr, byteIn};
              if (r_r.addr == scp_pkg::RBSEL_ADDR) begin
                r_nxt.readActive = byteIn[scp_pkg::RBSEL_BIT];
              end
            end
          end
        end
        scp_pkg::PH_READ: begin
          if (r_r.bitCnt == scp_pkg::BYTE_LAST) begin
            r_nxt.bitCnt = 4'h0;
            r_nxt.addr = stepAddr;
            r_nxt.rdReq = 1'b1;
            r_nxt.rdAddr = stepAddr;
          end
        end
        default: begin
          r_nxt.phase = scp_pkg::PH_IDLE;
        end
      endcase
    end else if (fall && r_r.phase == scp_pkg::PH_READ) begin
      if (r_r.lsbCur) begin
        r_nxt.sdioOut = r_r.txShift[0];
        r_nxt.sdoOut = r_r.txShift[0];
        r_nxt.txShift = {1'b0, r_r.txShift[7:1]};
      end else begin
        r_nxt.sdioOut = r_r.txShift[7];
        r_nxt.sdoOut = r_r.txShift[7];
        r_nxt.txShift = {r_r.txShift[6:0], 1'b0};
      end
      r_nxt.sdioOe = !r_r.fourWire;
      r_nxt.sdoOe = r_r.fourWire;
    end

    // fetched byte arrives two cycles after the request
    if (r_r.rdLoad) begin
      r_nxt.txShift = (r_r.rdAddr == scp_pkg::CFG_ADDR) ? r_r.cfg :
        rdData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_r <= '0;
      r_r.csS <= 2'h3;
      r_r.phase <= scp_pkg::PH_IDLE;
      r_r.cfg <= scp_pkg::CFG_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sdioOut = r_r.sdioOut;
  assign sdioOe = r_r.sdioOe;
  assign serialDataOut = r_r.sdoOut;
  assign serialDataOutOe = r_r.sdoOe;
  assign spiActive = r_r.spiActive;
  assign i2cAddr = r_r.i2cAddr;
  assign i2cAddrValid = r_r.i2cValid;
  assign rdReq = r_r.rdReq;
  assign rdAddr = r_r.rdAddr;
  assign readActive = r_r.readActive;
  assign wrOverflow = r_r.overflow;
  assign ioUpdate = r_r.ioUpdate;
  assign syncPulseRequest = r_r.syncReq;

endmodule

// ---- verification/scp_spi_checker_assertions.sv ----
// Purpose: pin-level checks of the serial control port slave
// Assumes: one clock domain, rst synchronous active high
// Notes: bound to every scp_spi_slave instance
`timescale 1ns/10ps
module scp_spi_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic csN,
  input wire logic sdioOe,
  input wire logic serialDataOutOe,
  input wire logic spiActive,
  input wire logic [6:0] i2cAddr,
  input wire logic i2cAddrValid,
  input wire logic rdReq,
  input wire logic [12:0] rdAddr,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic [12:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic ioUpdate,
  input wire logic syncPulseRequest
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  a_cs_quiet:
    assert property (csN [*5] |-> !sdioOe && !serialDataOutOe)
    else $error("data pin driven while deselected");
  a_one_pin:
    assert property (!(sdioOe && serialDataOutOe))
    else $error("both data pins driven");
  a_fetch_pulse:
    assert property (rdReq |=> !rdReq)
    else $error("fetch request longer than one cycle");
  a_fetch_hold:
    assert property (rdReq |=> $stable(rdAddr) [*2])
    else $error("fetch address moved during fetch");
  a_word_hold:
    assert property (wrValid && !wrReady |=>
      wrValid && $stable(wrAddr) && $stable(wrData))
    else $error("write word dropped or changed while stalled");
  a_update_cause:
    assert property (ioUpdate |-> $past(wrValid && wrReady &&
      wrAddr == scp_pkg::UPDATE_ADDR && wrData[scp_pkg::UPDATE_BIT]))
    else $error("update pulse without commit write");
  a_sync_cause:
    assert property (syncPulseRequest |-> $past(wrValid && wrReady &&
      wrAddr == scp_pkg::SYNC_ADDR && wrData[scp_pkg::SYNC_BIT]))
    else $error("sync request without its write");
  a_spi_excl:
    assert property (spiActive |-> !i2cAddrValid)
    else $error("both protocols selected");
  a_i2c_prefix:
    assert property (i2cAddrValid |-> i2cAddr[6:1] == 6'h2A)
    else $error("two-wire address prefix wrong");
endmodule

bind scp_spi_slave scp_spi_checker u_chk (
  .clock, .rst, .csN, .sdioOe, .serialDataOutOe, .spiActive,
  .i2cAddr, .i2cAddrValid, .rdReq, .rdAddr, .wrValid, .wrReady,
  .wrAddr, .wrData, .ioUpdate, .syncPulseRequest
);

// ---- verification/scp_spi_master.sv ----
// Purpose: host side SPI master for the control port slave
// Assumes: sclk idles low, period 125 ns, framed by csN
// Notes: released sdio shows the inverse of the last driven bit
`timescale 1ns/10ps
module scp_spi_master (
  output logic sclk,
  output logic csN,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic serialDataOut
);
  logic mDrv = 1'b0;
  logic mVal = 1'b0;

  assign sdioIn = sdioOe ? sdioOut : (mDrv ? mVal : ~mVal);

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
  end

  task automatic bit_io(input logic b, four, output logic r);
    if (mDrv) mVal = b;
    #62.5;
    sclk = 1'b1;
    r = four ? serialDataOut : sdioIn;
    #62.5;
    sclk = 1'b0;
  endtask

  // ib instruction bits, then n payload bytes taken from wd upper first
  task automatic xfer(input logic [15:0] ins, input int ib, n,
    input logic [15:0] wd, input logic lsb, four,
    output logic [15:0] rw);
    logic r;
    rw = 16'h0000;
    mDrv = 1'b1;
    csN = 1'b0;
    for (int i = 0; i < ib; i++)
      bit_io(lsb ? ins[i] : ins[15-i], four, r);
    mDrv = ~ins[15];
    for (int k = 0; k < n; k++)
      for (int i = 0; i < 8; i++) begin
        bit_io(lsb ? wd[8*(1-k)+i] : wd[8*(1-k)+7-i], four, r);
        rw[lsb ? 8*(1-k)+i : 8*(1-k)+7-i] = r;
      end
    #62.5;
    csN = 1'b1;
    mDrv = 1'b0;
    #250;
  endtask
endmodule

// ---- verification/test_spi_control_port_slave.sv ----
// Purpose: self-checking bench of the serial control port slave
// Assumes: bench plays the register map on the read and write ports
// Notes: map returns address low byte xor 5A, stalls every other cycle
`timescale 1ns/10ps
module test_spi_control_port_slave;
  logic clock, rst, sclk, csN, sdioIn, sdioOut, sdioOe;
  logic serialDataOut, serialDataOutOe, portSelectPin0, portSelectPin1;
  logic spiActive, i2cAddrValid, rdReq, readActive, wrValid, wrReady;
  logic wrOverflow, ioUpdate, syncPulseRequest;
  logic [6:0] i2cAddr;
  logic [12:0] rdAddr, wrAddr;
  logic [7:0] rdData, wrData;
  logic [15:0] rw;
  logic [20:0] wq[$];
  int fails, totalChecks, upd, syn, rq;

  scp_spi_slave dut (.clock, .rst, .sclk, .csN, .sdioIn, .sdioOut,
    .sdioOe, .serialDataOut, .serialDataOutOe, .portSelectPin0,
    .portSelectPin1, .spiActive, .i2cAddr, .i2cAddrValid, .rdReq,
    .rdAddr, .rdData, .readActive, .wrValid, .wrReady, .wrAddr,
    .wrData, .wrOverflow, .ioUpdate, .syncPulseRequest);
  scp_spi_master m (.sclk, .csN, .sdioIn, .sdioOut, .sdioOe,
    .serialDataOut);

  always #5 clock = ~clock;

  // map side watches mid-cycle, where the block's flops have settled
  always @(negedge clock) begin
    if (wrValid && wrReady) wq.push_back({wrAddr, wrData});
    if (ioUpdate) upd++;
    if (syncPulseRequest) syn++;
    if (rdReq) rq++;
  end

  always @(posedge clock) begin
    #1;
    rdData = rdAddr[7:0] ^ 8'h5A;
    wrReady = ~wrReady;
  end

  task chk(input logic [31:0] s, e);
    totalChecks++;
    if (s !== e) begin
      fails++;
      $display("wrong value t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task end_of_test;
    $display("checks %0d fails %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task t_reset;
    chk(spiActive, 1);
    chk({sdioOe, serialDataOutOe}, 0);
  endtask

  task t_write;
    m.xfer(16'h6010, 16, 2, 16'hA501, 1'b0, 1'b0, rw);
    chk(wq.size(), 2);
    chk(wq.pop_front(), {13'h0010, 8'hA5});
    chk(wq.pop_front(), {13'h000F, 8'h01});
    chk(upd, 1);
  endtask

  task t_read3;
    m.xfer(16'h8020, 16, 2, 16'h0000, 1'b0, 1'b0, rw);
    chk(rw, {8'h20 ^ 8'h5A, 8'h1F ^ 8'h5A});
    chk(wq.size(), 0);
  endtask

  task t_cfg_read4;
    m.xfer(16'h0000, 16, 1, 16'h7E00, 1'b0, 1'b0, rw);
    chk(wq.size(), 0);
    m.xfer(16'h8030, 16, 2, 16'h0000, 1'b1, 1'b1, rw);
    chk(rw, {8'h30 ^ 8'h5A, 8'h31 ^ 8'h5A});
  endtask

  task automatic t_partial;
    int r0;
    r0 = rq;
    m.xfer(16'h8050, 8, 0, 16'h0000, 1'b1, 1'b1, rw);
    chk(rq, r0);
    chk(wq.size(), 0);
  endtask

  task t_flags;
    m.xfer(16'h0001, 16, 1, 16'h2000, 1'b1, 1'b0, rw);
    chk(readActive, 1);
    m.xfer(16'h0402, 16, 2, 16'h0001, 1'b1, 1'b0, rw);
    chk(syn, 1);
    chk(wq[1], {13'h0402, 8'h00});
    chk(wq[2], {13'h0403, 8'h01});
    chk(wrOverflow, 0);
    wq.delete();
  endtask

  task t_strap(input logic [1:0] p, input logic [6:0] a);
    @(posedge clock);
    #1;
    {portSelectPin1, portSelectPin0} = p;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk({spiActive, i2cAddrValid, i2cAddr}, {2'b01, a});
    {portSelectPin1, portSelectPin0} = 2'b00;
    m.xfer(16'h0010, 16, 1, 16'h5500, 1'b0, 1'b0, rw);
    chk(spiActive, 0);
    chk(wq.size(), 0);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    wrReady = 1'b0;
    rdData = 8'h00;
    portSelectPin0 = 1'b0;
    portSelectPin1 = 1'b0;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    t_reset;
    t_write;
    t_read3;
    t_cfg_read4;
    t_partial;
    t_flags;
    t_strap(2'b01, 7'b1010100);
    t_strap(2'b11, 7'b1010101);
    end_of_test;
  end

  initial begin
    #400000;
    fails++;
    end_of_test;
  end
endmodule
